// >>> verilog/clock_output_pkg.sv
// Constants, register map and state codes of the clock output power control block
package clock_output_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int          NUM_PAIRS      = 8;
    localparam int          SYNC_STAGES    = 2;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0]  OFS_PAIR_EN    = 8'h00;
    localparam logic [7:0]  OFS_CONFIG     = 8'h04;
    localparam logic [7:0]  OFS_SLEW       = 8'h08;
    localparam logic [7:0]  OFS_AMPLITUDE  = 8'h0c;
    localparam logic [7:0]  OFS_STATUS     = 8'h10;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int          LAN_WAKE_BIT   = 5;
    localparam int          SLEW_W         = NUM_PAIRS + 1;
    localparam int          AMP_W          = 2;
    localparam logic [7:0]  PAIR_EN_RESET  = 8'hff;
    localparam logic [7:0]  CONFIG_RESET   = 8'h00;
    localparam logic [8:0]  SLEW_RESET     = 9'h1ff;
    localparam logic [1:0]  AMP_RESET      = 2'h1;

    // Status word layout
    localparam int          ST_ADDR_LSB    = 0;
    localparam int          ST_SPREAD_LSB  = 7;
    localparam int          ST_CONFIGURED  = 9;
    localparam int          ST_PLL_LOCK    = 10;
    localparam int          ST_POWER_DOWN  = 11;
    localparam int          ST_PAIRS_LSB   = 12;
    localparam int          ST_REF_ACTIVE  = 20;

    // ****************************************************************
    // Bus addresses and spread codes
    // ****************************************************************
    localparam logic [6:0]  BUS_ADDR_LOW   = 7'h68;
    localparam logic [6:0]  BUS_ADDR_HIGH  = 7'h6a;
    localparam logic [1:0]  SPREAD_OFF     = 2'h0;
    localparam logic [1:0]  SPREAD_QUARTER = 2'h1;
    localparam logic [1:0]  SPREAD_HALF    = 2'h2;

    // Strap pin level encoding on spread_strap
    localparam logic [1:0]  STRAP_LOW      = 2'h0;
    localparam logic [1:0]  STRAP_MID      = 2'h1;
    localparam logic [1:0]  STRAP_HIGH     = 2'h2;

    // ****************************************************************
    // Power states
    // ****************************************************************
    typedef enum logic [2:0]
    {
        ST_UNCONF = 3'b001,
        ST_RUN    = 3'b010,
        ST_PDOWN  = 3'b100
    } power_state_e;

endpackage : clock_output_pkg

// >>> verilog/clock_pair_gate.sv
// Gate for one sampled clock, glitch-free on the true output, with a complement output whose high phases are shortened at start and stop
`timescale 1ns/100ps

module clock_pair_gate
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic clk_level,
    input  wire logic clk_fall,
    input  wire logic run,
    output logic      true_q,
    output logic      comp_q,
    output logic      active_q
);

    logic active_d;
    logic true_d;
    logic comp_d;

    // ****************************************************************
    // Gate follows run only on a falling edge, so no true-output cycle is cut short; the first and last complement high phases are
    // ****************************************************************
    always_comb
    begin
        active_d = active_q;
        if (clk_fall)
        begin
            active_d = run;
        end
        true_d = active_q & clk_level;
        comp_d = active_q & ~clk_level;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            active_q <= 1'b0;
            true_q   <= 1'b0;
            comp_q   <= 1'b0;
        end
        else
        begin
            active_q <= active_d;
            true_q   <= true_d;
            comp_q   <= comp_d;
        end
    end

endmodule : clock_pair_gate

// >>> verilog/clock_output_power_control.sv
// Power, strap and output gating control with an AHB-Lite register slave
`timescale 1ns/100ps

module clock_output_power_control
(
    input  wire logic                                    hclk,
    input  wire logic                                    hresetn,
    input  wire logic                                    hsel,
    input  wire logic [31:0]                             haddr,
    input  wire logic [1:0]                              htrans,
    input  wire logic                                    hwrite,
    input  wire logic [2:0]                              hsize,
    input  wire logic [31:0]                             hwdata,
    input  wire logic                                    hready,
    output logic                                         hreadyout,
    output logic                                         hresp,
    output logic [31:0]                                  hrdata,
    input  wire logic                                    power_good_powerdown_n,
    input  wire logic                                    pll_lock,
    input  wire logic [1:0]                              spread_strap,
    input  wire logic [clock_output_pkg::NUM_PAIRS-1:0]  pair_enable_n,
    input  wire logic                                    link_clk,
    input  wire logic                                    xtal_clk,
    input  wire logic                                    address_strap_in,
    output logic                                         address_strap_out,
    output logic                                         address_strap_oe,
    output logic [clock_output_pkg::NUM_PAIRS-1:0]       paired_clock_out,
    output logic [clock_output_pkg::NUM_PAIRS-1:0]       paired_clock_out_n,
    output logic [6:0]                                   bus_address_q,
    output logic [1:0]                                   spread_select_q,
    output logic [clock_output_pkg::SLEW_W-1:0]          slew_q,
    output logic [clock_output_pkg::AMP_W-1:0]           amplitude_q
);

    import clock_output_pkg::*;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int SYNC_W = NUM_PAIRS + 7;

    logic [SYNC_W-1:0]    sync_in;
    logic [SYNC_W-1:0]    sync1_q;
    logic [SYNC_W-1:0]    sync2_q;
    logic                 pg_s;
    logic                 lock_s;
    logic [1:0]           spread_s;
    logic                 addr_s;
    logic [NUM_PAIRS-1:0] pair_en_n_s;
    logic                 link_s;
    logic                 xtal_s;

    assign sync_in = {xtal_clk, link_clk, pair_enable_n, address_strap_in,
                      spread_strap, pll_lock, power_good_powerdown_n};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= sync_in;
            sync2_q <= sync1_q;
        end
    end

    assign pg_s        = sync2_q[0];
    assign lock_s      = sync2_q[1];
    assign spread_s    = sync2_q[3:2];
    assign addr_s      = sync2_q[4];
    assign pair_en_n_s = sync2_q[5 +: NUM_PAIRS];
    assign link_s      = sync2_q[NUM_PAIRS+5];
    assign xtal_s      = sync2_q[NUM_PAIRS+6];

    // ****************************************************************
    // Power state and strap latch
    // ****************************************************************
    power_state_e state_q;
    power_state_e state_d;
    logic [6:0]   bus_address_d;
    logic [1:0]   spread_select_d;

    always_comb
    begin
        state_d         = state_q;
        bus_address_d   = bus_address_q;
        spread_select_d = spread_select_q;
        case (state_q)
            ST_UNCONF:
            begin
                if (pg_s)
                begin
                    state_d       = ST_RUN;
                    bus_address_d = addr_s ? BUS_ADDR_HIGH : BUS_ADDR_LOW;
                    case (spread_s)
                        STRAP_HIGH: spread_select_d = SPREAD_HALF;
                        STRAP_MID:  spread_select_d = SPREAD_QUARTER;
                        default:    spread_select_d = SPREAD_OFF;
                    endcase
                end
            end
            ST_RUN:
            begin
                if (!pg_s)
                begin
                    state_d = ST_PDOWN;
                end
            end
            ST_PDOWN:
            begin
                if (pg_s)
                begin
                    state_d = ST_RUN;
                end
            end
            default:
            begin
                state_d = ST_UNCONF;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q         <= ST_UNCONF;
            bus_address_q   <= BUS_ADDR_LOW;
            spread_select_q <= SPREAD_OFF;
        end
        else
        begin
            state_q         <= state_d;
            bus_address_q   <= bus_address_d;
            spread_select_q <= spread_select_d;
        end
    end

    // ****************************************************************
    // AHB-Lite register slave
    // ****************************************************************
    logic [NUM_PAIRS-1:0] pair_en_q;
    logic [NUM_PAIRS-1:0] pair_en_d;
    logic [7:0]           config_q;
    logic [7:0]           config_d;
    logic [SLEW_W-1:0]    slew_d;
    logic [AMP_W-1:0]     amplitude_d;
    logic                 wr_pend_q;
    logic                 wr_pend_d;
    logic [7:0]           wr_addr_q;
    logic [7:0]           wr_addr_d;
    logic [31:0]          hrdata_d;
    logic [31:0]          status_w;
    logic                 take_w;
    logic [NUM_PAIRS-1:0] pair_active_w;
    logic                 ref_active_w;
    logic                 lan_wake_keepalive;

    assign take_w             = hsel & htrans[1] & hready;
    assign lan_wake_keepalive = config_q[LAN_WAKE_BIT];

    always_comb
    begin
        status_w = '0;
        status_w[ST_ADDR_LSB +: 7]         = bus_address_q;
        status_w[ST_SPREAD_LSB +: 2]       = spread_select_q;
        status_w[ST_CONFIGURED]            = (state_q != ST_UNCONF);
        status_w[ST_PLL_LOCK]              = lock_s;
        status_w[ST_POWER_DOWN]            = (state_q == ST_PDOWN);
        status_w[ST_PAIRS_LSB +: NUM_PAIRS] = pair_active_w;
        status_w[ST_REF_ACTIVE]            = ref_active_w;
    end

    always_comb
    begin
        pair_en_d   = pair_en_q;
        config_d    = config_q;
        slew_d      = slew_q;
        amplitude_d = amplitude_q;
        wr_pend_d   = 1'b0;
        wr_addr_d   = wr_addr_q;
        hrdata_d    = hrdata;
        if (wr_pend_q)
        begin
            case (wr_addr_q)
                OFS_PAIR_EN:   pair_en_d   = hwdata[NUM_PAIRS-1:0];
                OFS_CONFIG:    config_d    = hwdata[7:0];
                OFS_SLEW:      slew_d      = hwdata[SLEW_W-1:0];
                OFS_AMPLITUDE: amplitude_d = hwdata[AMP_W-1:0];
                default:       pair_en_d   = pair_en_q;
            endcase
        end
        if (take_w)
        begin
            wr_pend_d = hwrite;
            wr_addr_d = haddr[7:0];
            hrdata_d  = '0;
            if (!hwrite)
            begin
                case (haddr[7:0])
                    OFS_PAIR_EN:   hrdata_d[NUM_PAIRS-1:0] = pair_en_q;
                    OFS_CONFIG:    hrdata_d[7:0]           = config_q;
                    OFS_SLEW:      hrdata_d[SLEW_W-1:0]    = slew_q;
                    OFS_AMPLITUDE: hrdata_d[AMP_W-1:0]     = amplitude_q;
                    OFS_STATUS:    hrdata_d                = status_w;
                    default:       hrdata_d                = '0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pair_en_q   <= PAIR_EN_RESET;
            config_q    <= CONFIG_RESET;
            slew_q      <= SLEW_RESET;
            amplitude_q <= AMP_RESET;
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 8'h00;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end
        else
        begin
            pair_en_q   <= pair_en_d;
            config_q    <= config_d;
            slew_q      <= slew_d;
            amplitude_q <= amplitude_d;
            wr_pend_q   <= wr_pend_d;
            wr_addr_q   <= wr_addr_d;
            hrdata      <= hrdata_d;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end
    end

    // ****************************************************************
    // Output clock gating
    // ****************************************************************
    logic                 link_prev_q;
    logic                 xtal_prev_q;
    logic                 link_fall;
    logic                 xtal_fall;
    logic [NUM_PAIRS-1:0] pair_run;
    logic                 ref_run;
    logic                 address_strap_oe_d;

    assign link_fall = link_prev_q & ~link_s;
    assign xtal_fall = xtal_prev_q & ~xtal_s;
    assign ref_run   = (state_q == ST_RUN)
                       | ((state_q == ST_PDOWN) & lan_wake_keepalive);

    always_comb
    begin
        address_strap_oe_d = address_strap_oe | (state_q != ST_UNCONF);
        pair_run = (state_q == ST_RUN && lock_s)
                   ? (~pair_en_n_s & pair_en_q) : '0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            link_prev_q      <= 1'b0;
            xtal_prev_q      <= 1'b0;
            address_strap_oe <= 1'b0;
        end
        else
        begin
            link_prev_q      <= link_s;
            xtal_prev_q      <= xtal_s;
            address_strap_oe <= address_strap_oe_d;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PAIRS; gi++)
        begin : g_pair
            clock_pair_gate u_gate
            (
                .hclk      (hclk),
                .hresetn   (hresetn),
                .clk_level (link_s),
                .clk_fall  (link_fall),
                .run       (pair_run[gi]),
                .true_q    (paired_clock_out[gi]),
                .comp_q    (paired_clock_out_n[gi]),
                .active_q  (pair_active_w[gi])
            );
        end
    endgenerate

    clock_pair_gate u_ref_gate
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clk_level (xtal_s),
        .clk_fall  (xtal_fall),
        .run       (ref_run),
        .true_q    (address_strap_out),
        .comp_q    (),
        .active_q  (ref_active_w)
    );

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_addr_latch;
        (state_q == ST_UNCONF && pg_s) |=> (bus_address_q == ($past(addr_s) ? 7'h6a : 7'h68));
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("bus address not latched");

    property p_spread_latch;
        (state_q == ST_UNCONF && pg_s && spread_s == 2'h1) |=> spread_select_q == 2'h1;
    endproperty
    a_spread_latch: assert property (p_spread_latch) else $error("spread not latched");

    property p_unconf_quiet;
        (state_q == ST_UNCONF) |-> (!address_strap_oe && paired_clock_out == '0);
    endproperty
    a_unconf_quiet: assert property (p_unconf_quiet) else $error("output before config");

    property p_pd_pairs_off;
        (state_q == ST_PDOWN)[*8] ##1 (state_q == ST_PDOWN)[*2]
            |-> (paired_clock_out == '0 && paired_clock_out_n == '0);
    endproperty
    a_pd_pairs_off: assert property (p_pd_pairs_off) else $error("pair on in power-down");

    property p_ref_oe_sticky;
        address_strap_oe |=> address_strap_oe;
    endproperty
    a_ref_oe_sticky: assert property (p_ref_oe_sticky) else $error("crystal copy released");

    property p_pair_gate;
        ##1 ((pair_active_w & ~$past(pair_active_w)) & ~$past(pair_run)) == '0;
    endproperty
    a_pair_gate: assert property (p_pair_gate) else $error("pair started unqualified");

    property p_ref_off;
        (state_q == ST_PDOWN && !lan_wake_keepalive)[*8] ##1
            (state_q == ST_PDOWN && !lan_wake_keepalive)[*4] |-> !address_strap_out;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("crystal copy runs");

    property p_lock_hold;
        (!lock_s && pair_active_w == '0) |=> pair_active_w == '0;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("pair on before lock");

    property p_clean_edge;
        !link_fall |=> $stable(pair_active_w);
    endproperty
    a_clean_edge: assert property (p_clean_edge) else $error("pair gated mid cycle");

    property p_slew_write;
        (wr_pend_q && wr_addr_q == 8'h08) |=> slew_q == $past(hwdata[8:0]);
    endproperty
    a_slew_write: assert property (p_slew_write) else $error("slew not written");

    property p_strap_keep;
        (state_q != ST_UNCONF) |=> ($stable(bus_address_q) && $stable(spread_select_q));
    endproperty
    a_strap_keep: assert property (p_strap_keep) else $error("strap changed");

    property p_startup;
        state_q == ST_UNCONF ##1 state_q == ST_RUN;
    endproperty
    c_startup: cover property (p_startup);

    property p_wake_ref;
        state_q == ST_PDOWN && lan_wake_keepalive && address_strap_out;
    endproperty
    c_wake_ref: cover property (p_wake_ref);

    property p_pair_running;
        pair_active_w != '0 ##1 state_q == ST_PDOWN;
    endproperty
    c_pair_running: cover property (p_pair_running);

endmodule : clock_output_power_control

// >>> tb/board_model.sv
// Board side model: free running clocks and the shared strap pin wire
`timescale 1ns/100ps

module board_model
(
    input  wire logic strap_level,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      link_clk,
    output logic      xtal_clk,
    output logic      pin_wire
);
    // Strap resistor sets the level only while the device leaves the pin undriven
    assign pin_wire = pin_oe ? pin_out : strap_level;

    // Link clock stands for the free running PLL output, phase unrelated to hclk
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #80 link_clk = ~link_clk;
    end

    initial
    begin
        xtal_clk = 1'b0;
        forever #100 xtal_clk = ~xtal_clk;
    end
endmodule : board_model

// >>> tb/tb_clock_output_power_control.sv
// Self-checking bench of the clock output power control block
`timescale 1ns/100ps

module tb_clock_output_power_control;
    import clock_output_pkg::*;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pg, pll_lock;
    logic        strap_level, strap_out, strap_oe, strap_in, link_clk, xtal_clk, st;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [31:0] rexp [4];
    logic [1:0]  htrans, spread_strap, spread_q, amp_q;
    logic [2:0]  hsize;
    logic [7:0]  pair_enable_n, pout, pout_n, pe_n, bits;
    logic [8:0]  slew_q;
    logic [6:0]  addr_q;
    logic [15:0] lfsr;
    int          err_total = 0;
    int          comparisons = 0;
    int          cyc = 0;

    clock_output_power_control uut
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .power_good_powerdown_n(pg), .pll_lock(pll_lock), .spread_strap(spread_strap),
        .pair_enable_n(pair_enable_n), .link_clk(link_clk), .xtal_clk(xtal_clk),
        .address_strap_in(strap_in), .address_strap_out(strap_out),
        .address_strap_oe(strap_oe), .paired_clock_out(pout), .paired_clock_out_n(pout_n),
        .bus_address_q(addr_q), .spread_select_q(spread_q), .slew_q(slew_q),
        .amplitude_q(amp_q)
    );

    board_model board
    (
        .strap_level(strap_level), .pin_out(strap_out), .pin_oe(strap_oe),
        .link_clk(link_clk), .xtal_clk(xtal_clk), .pin_wire(strap_in)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    // Activity of crystal copy (bit 8) and pairs over a window after settling
    task automatic observe(input logic [8:0] exp);
        logic [8:0] prev, tog, hi;
        logic [7:0] prev_n, tog_n;
        repeat (40) @(posedge hclk);
        prev = {strap_out, pout};
        prev_n = pout_n;
        tog = '0;
        tog_n = '0;
        hi = '0;
        repeat (48)
        begin
            @(posedge hclk);
            tog |= prev ^ {strap_out, pout};
            tog_n |= prev_n ^ pout_n;
            hi |= {strap_out, pout} | {1'b0, pout_n};
            prev = {strap_out, pout};
            prev_n = pout_n;
        end
        chk({23'h0, tog}, {23'h0, exp});
        chk({23'h0, hi}, {23'h0, exp});
        chk({24'h0, tog_n}, {24'h0, exp[7:0]});
    endtask : observe

    // ****************************************************************
    // Clock, timeout and main sequence
    // ****************************************************************
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    initial
    begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata, hresetn, pg, pll_lock} = '0;
        {strap_level, spread_strap} = '0;
        pair_enable_n = 8'hff;
        lfsr = 16'ha737;
        rexp = '{{24'h0, PAIR_EN_RESET}, {24'h0, CONFIG_RESET}, {23'h0, SLEW_RESET},
                 {30'h0, AMP_RESET}};
        for (int k = 0; k < 3; k++)
        begin
            lfsr = lfsr_next(lfsr);
            st = lfsr[0];
            hresetn <= 1'b0;
            pg <= 1'b0;
            strap_level <= st;
            spread_strap <= 2'(k);
            repeat (20) @(posedge hclk);
            hresetn <= 1'b1;
            @(posedge hclk);
            for (int i = 0; i < 4; i++)
            begin
                ahb(32'(4 * i), 1'b0, 32'h0);
                chk(rd, rexp[i]);
            end
            chk({31'h0, strap_oe}, 32'h0);
            ahb({24'h0, OFS_STATUS}, 1'b0, 32'h0);
            chk({31'h0, rd[ST_CONFIGURED]}, 32'h0);
            pg <= 1'b1;
            repeat (8) @(posedge hclk);
            chk({25'h0, addr_q}, st ? 32'h6a : 32'h68);
            chk({30'h0, spread_q}, {30'h0, (k == 2) ? SPREAD_HALF : 2'(k)});
            chk({31'h0, strap_oe}, 32'h1);
            ahb({24'h0, OFS_STATUS}, 1'b0, 32'h0);
            chk({31'h0, rd[ST_CONFIGURED]}, 32'h1);
        end
        pair_enable_n <= 8'h00;
        observe(9'h100);
        pll_lock <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            lfsr = lfsr_next(lfsr);
            pe_n = (i == 0) ? 8'h00 : lfsr[7:0];
            bits = (i == 0) ? 8'hff : lfsr[15:8];
            ahb({24'h0, OFS_PAIR_EN}, 1'b1, {24'h0, bits});
            pair_enable_n <= pe_n;
            observe({1'b1, ~pe_n & bits});
        end
        lfsr = lfsr_next(lfsr);
        ahb({24'h0, OFS_SLEW}, 1'b1, {23'h0, lfsr[8:0]});
        ahb({24'h0, OFS_AMPLITUDE}, 1'b1, {30'h0, lfsr[10:9]});
        @(posedge hclk);
        chk({23'h0, slew_q}, {23'h0, lfsr[8:0]});
        chk({30'h0, amp_q}, {30'h0, lfsr[10:9]});
        ahb({24'h0, OFS_SLEW}, 1'b0, 32'h0);
        chk(rd, {23'h0, lfsr[8:0]});
        ahb(32'h14, 1'b1, 32'hffffffff);
        ahb(32'h14, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        pg <= 1'b0;
        strap_level <= ~st;
        spread_strap <= 2'h0;
        observe(9'h000);
        chk({31'h0, strap_oe}, 32'h1);
        pg <= 1'b1;
        observe({1'b1, ~pe_n & bits});
        chk({25'h0, addr_q}, st ? 32'h6a : 32'h68);
        chk({30'h0, spread_q}, {30'h0, SPREAD_HALF});
        ahb({24'h0, OFS_CONFIG}, 1'b1, 32'h1 << LAN_WAKE_BIT);
        pg <= 1'b0;
        observe(9'h100);
        tally_and_finish();
    end
endmodule : tb_clock_output_power_control
